/* hw/itrf_params.svh */
/*
  Constants of the architectural register file: counts, register offsets,
  field positions, reset values and fixed encodings.
  Assumes it is included by bare name, once per compile unit.
*/
`ifndef ITRF_PARAMS_SVH
`define ITRF_PARAMS_SVH

// register counts
`define ITRF_GR_N        128
`define ITRF_FR_N        128
`define ITRF_PR_N        64
`define ITRF_BR_N        8
`define ITRF_AR_N        128
`define ITRF_AR_EPILOGUE 7'h42
`define ITRF_STK_BASE    7'h20
`define ITRF_STK_N       7'h60
`define ITRF_ADVANCED_LOAD_TABLE_N      32
// registers holding legacy state
`define ITRF_LEG_LO      7'h08
`define ITRF_LEG_HI      7'h0f

// bus offsets
`define ITRF_OFS_CMD     8'h00
`define ITRF_OFS_DLO     8'h04
`define ITRF_OFS_DHI     8'h08
`define ITRF_OFS_DEX     8'h0c
`define ITRF_OFS_RSEL    8'h10
`define ITRF_OFS_RLO     8'h14
`define ITRF_OFS_RHI     8'h18
`define ITRF_OFS_REX     8'h1c
`define ITRF_OFS_CTRL    8'h20
`define ITRF_OFS_STAT    8'h24
`define ITRF_OFS_ADVANCED_LOAD_TABLE    8'h28

// command fields
`define ITRF_CMD_OP      3:0
`define ITRF_CMD_DST     10:4
`define ITRF_CMD_SRC     17:11
`define ITRF_CMD_QP      23:18
// read select fields
`define ITRF_RSEL_CLS    2:0
`define ITRF_RSEL_IDX    10:4
// data extension fields
`define ITRF_DEX_SE      17:0
`define ITRF_DEX_NAT     31
`define ITRF_DEX_VALID   30
// control bits
`define ITRF_CTRL_RSE    0
`define ITRF_CTRL_FPPOL  1
`define ITRF_CTRL_CVT    2
// status bits
`define ITRF_ST_LEG      0
`define ITRF_ST_RSE      1
`define ITRF_ST_FCONST   2
`define ITRF_ST_FABORT   3
`define ITRF_ST_FFP      4
`define ITRF_ST_PEND     5
`define ITRF_ST_HIT      6
`define ITRF_ST_CLEAN    14:8

// fixed floating-point encodings, sign:exponent:mantissa
`define ITRF_FP_ZERO     82'h0
`define ITRF_FP_ONE      {1'b0, 17'h0ffff, 64'h8000000000000000}
`define ITRF_FP_DEFERRED_FAULT_FP_VALUE   {1'b0, 17'h1fffe, 64'h0000000000000000}
`define ITRF_FP_SNAN     {1'b0, 17'h1ffff, 64'h8000000000000001}
`define ITRF_VEC_SE      18'h1003e

// reset values
`define ITRF_RST_CTRL    3'h0

`endif

/* hw/itrf_pkg.sv */
/*
  Types of the architectural register file: command codes, read classes
  and the packed state of the top module.
  Assumes itrf_params.svh is on the include path.
*/
`include "itrf_params.svh"

package itrf_pkg;

  // commands written to the command register
  typedef enum logic [3:0] {
    OP_NOP, OP_WR_GR, OP_WR_FR, OP_WR_PR, OP_WR_BR, OP_WR_AR, OP_WR_IP,
    OP_SET_NAT, OP_ENTER, OP_LEAVE, OP_LEG_INT, OP_LEG_FP, OP_LEG_VEC,
    OP_FLUSH, OP_ADVANCED_LOAD_TABLE_SET, OP_ADVANCED_LOAD_TABLE_CHECK
  } itrf_op_type;

  // register classes seen through the read window
  typedef enum logic [2:0] {
    CLS_GR, CLS_FR, CLS_PR, CLS_BR, CLS_AR, CLS_IP
  } itrf_cls_type;

  typedef struct packed {
    logic [`ITRF_GR_N-1:0][63:0]  gr;
    logic [`ITRF_GR_N-1:0]        gr_nat;
    logic [`ITRF_GR_N-1:0]        stk_valid;
    logic [`ITRF_FR_N-1:0][81:0]  fr;
    logic [`ITRF_PR_N-1:0]        pr;
    logic [`ITRF_BR_N-1:0][63:0]  br;
    logic [`ITRF_AR_N-1:0][63:0]  ar;
    logic [63:0]                  ip;
    logic [`ITRF_ADVANCED_LOAD_TABLE_N-1:0]      advanced_load_table;
    logic                         advanced_load_table_hit;
    logic [6:0]                   clean;
    logic                         legacy;
    logic                         rse_en;
    logic                         rse_active;
    logic                         fp_pol;
    logic                         cvt_entry;
    logic                         abort_pend;
    logic                         f_const;
    logic                         f_abort;
    logic                         f_fp;
    logic [63:0]                  d_mant;
    logic [17:0]                  d_se;
    logic                         d_nat;
    logic [10:0]                  rsel;
    logic [7:0]                   haddr_q;
    logic                         wr_pend;
    logic                         rd_pend;
    logic                         hreadyout;
    logic [31:0]                  hrdata;
  } itrf_state_type;

endpackage : itrf_pkg

/* hw/itrf_top.sv */
/*
  Architectural register file with legacy instruction set transitions,
  reached over an AHB-Lite slave port. Commands written to the command
  register stand in for committed instructions.
  Assumes one clock, asynchronous active-low reset, single word transfers.
*/
// How it works
// - stack engine stays inactive during legacy execution, whatever its enable says
// - leaving legacy invalidates stacked registers and zeroes the clean count
// - entering legacy code discards every advanced-load table entry
// - deferred-fault bit in legacy state at entry arms an abort on legacy instructions
// - an abort may end a legacy instruction after it has changed state
// - deferred-fault fp value may become a signaling NaN at entry or consumption
// - legacy fp use of deferred-fault value propagates it or faults; with policy 0 and fp register zero or one as target it is dropped without fault
// - vector instructions ignore the deferred-fault encoding, use the mantissa
// - 128 general registers of 64 bits, each with a deferred-fault bit
// - general register zero reads 0; writing it faults
// - 128 floating-point registers of 82 bits
// - fp registers zero and one read +0.0 and +1.0; writing them faults
// - 64 one-bit predicate registers
// - predicate zero reads 1; writes to it vanish without fault
// - 8 branch registers of 64 bits
// - 128 application register slots; index 66 is the loop epilogue counter
// - 64-bit instruction pointer
// - false qualifying predicate discards results of predicated commands without fault; legacy, enter, leave and flush ignore it
`include "itrf_params.svh"
`timescale 1ns/1ps
`default_nettype none

module itrf_top (
  // clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // core events and state
  input  wire logic        legacy_interrupt,
  output logic             legacy_mode,
  output logic             rse_active
);

  itrf_pkg::itrf_state_type s;
  itrf_pkg::itrf_state_type n;
  // one struct, so ce freezes all flops

  ////////////////////////////////////////////////////////////////////////
  // read helpers
  // constants decoded on read
  // so a faulted write never shows

  // predicate zero is hardwired true
  function automatic logic pred_rd(input itrf_pkg::itrf_state_type st,
                                   input logic [5:0] idx);
    pred_rd = (idx == 6'h0) ? 1'b1 : st.pr[idx];
  endfunction : pred_rd

  // constants override storage, so a faulted write can never show
  function automatic logic [81:0] fr_rd(input itrf_pkg::itrf_state_type st,
                                        input logic [6:0] idx);
    if (idx == 7'h0) begin
      fr_rd = `ITRF_FP_ZERO;
    end else if (idx == 7'h1) begin
      fr_rd = `ITRF_FP_ONE;
    end else begin
      fr_rd = st.fr[idx];
    end
  endfunction : fr_rd

  // storage at index zero ignored
  function automatic logic [63:0] gr_rd(input itrf_pkg::itrf_state_type st,
                                        input logic [6:0] idx);
    gr_rd = (idx == 7'h0) ? 64'h0 : st.gr[idx];
  endfunction : gr_rd

  ////////////////////////////////////////////////////////////////////////
  // next state

  logic                  take;
  logic [81:0]           sel_val;
  logic [81:0]           src_fr;
  logic                  sel_nat;
  logic                  sel_ok;
  logic                  qp_true;
  logic                  pend;
  logic [31:0]           word;
  logic [6:0]            dst;
  logic [6:0]            src;
  logic [6:0]            ridx;
  itrf_pkg::itrf_op_type op;

  // only haddr[7:0] decoded
  // hsize ignored, hresp always okay
  // stalled address waits for hready
  assign take = hsel & htrans[1] & hready;

  // hold by default
  always_comb begin
    n       = s;
    sel_val = 82'h0;
    src_fr  = 82'h0;
    sel_nat = 1'b0;
    sel_ok  = 1'b1;
    qp_true = 1'b0;
    pend    = 1'b0;
    word    = 32'h0;
    dst     = hwdata[`ITRF_CMD_DST];
    src     = hwdata[`ITRF_CMD_SRC];
    ridx    = s.rsel[`ITRF_RSEL_IDX];
    op      = itrf_pkg::itrf_op_type'(hwdata[`ITRF_CMD_OP]);

    // command codes:
    //   0      no operation
    //   1..7   predicated writes
    //   8, 9   enter, leave legacy
    //   10..12 legacy moves
    //   13     stack flush
    //   14, 15 table set, check
    //   qp gates 1..7, 14, 15

    // read window value, taken from the selected class
    case (itrf_pkg::itrf_cls_type'(s.rsel[`ITRF_RSEL_CLS]))
      itrf_pkg::CLS_GR: begin
        sel_val = {18'h0, gr_rd(s, ridx)};
        sel_nat = (ridx != 7'h0) & s.gr_nat[ridx];
        sel_ok  = (ridx < `ITRF_STK_BASE) | s.stk_valid[ridx];
      end
      itrf_pkg::CLS_FR: sel_val = fr_rd(s, ridx);
      itrf_pkg::CLS_PR: sel_val = {81'h0, pred_rd(s, ridx[5:0])};
      itrf_pkg::CLS_BR: sel_val = {18'h0, s.br[ridx[2:0]]};
      itrf_pkg::CLS_AR: sel_val = {18'h0, s.ar[ridx]};
      itrf_pkg::CLS_IP: sel_val = {18'h0, s.ip};
      default:          sel_val = 82'h0;
    endcase

    // second cycle of a read: state already holds any prior write
    // hrdata stands until next read
    n.hreadyout = 1'b1;
    if (s.rd_pend) begin
      case (s.haddr_q)
        `ITRF_OFS_DLO:  word = s.d_mant[31:0];
        `ITRF_OFS_DHI:  word = s.d_mant[63:32];
        `ITRF_OFS_DEX:  word = {s.d_nat, 13'h0, s.d_se};
        `ITRF_OFS_RSEL: word = {21'h0, s.rsel};
        `ITRF_OFS_RLO:  word = sel_val[31:0];
        `ITRF_OFS_RHI:  word = sel_val[63:32];
        `ITRF_OFS_REX:  word = {sel_nat, sel_ok, 12'h0, sel_val[81:64]};
        `ITRF_OFS_CTRL: word = {29'h0, s.cvt_entry, s.fp_pol, s.rse_en};
        `ITRF_OFS_STAT: begin
          word[`ITRF_ST_LEG]    = s.legacy;
          word[`ITRF_ST_RSE]    = s.rse_active;
          word[`ITRF_ST_FCONST] = s.f_const;
          word[`ITRF_ST_FABORT] = s.f_abort;
          word[`ITRF_ST_FFP]    = s.f_fp;
          word[`ITRF_ST_PEND]   = s.abort_pend;
          word[`ITRF_ST_HIT]    = s.advanced_load_table_hit;
          word[`ITRF_ST_CLEAN]  = s.clean;
        end
        `ITRF_OFS_ADVANCED_LOAD_TABLE: word = s.advanced_load_table;
        default:        word = 32'h0; // unmapped reads as zero
      endcase
      n.hrdata  = word;
      n.rd_pend = 1'b0;
    end

    // write data phase
    // hwdata lands a cycle after address
    n.wr_pend = 1'b0;
    if (s.wr_pend) begin
      case (s.haddr_q)
        `ITRF_OFS_DLO:  n.d_mant[31:0]  = hwdata;
        `ITRF_OFS_DHI:  n.d_mant[63:32] = hwdata;
        `ITRF_OFS_DEX: begin
          n.d_se  = hwdata[`ITRF_DEX_SE];
          n.d_nat = hwdata[`ITRF_DEX_NAT];
        end
        `ITRF_OFS_RSEL: n.rsel = hwdata[10:0];
        `ITRF_OFS_CTRL: begin
          n.rse_en    = hwdata[`ITRF_CTRL_RSE];
          n.fp_pol    = hwdata[`ITRF_CTRL_FPPOL];
          n.cvt_entry = hwdata[`ITRF_CTRL_CVT];
        end
        `ITRF_OFS_STAT: begin
          // write one to clear; no event shares this cycle
          if (hwdata[`ITRF_ST_FCONST]) n.f_const = 1'b0;
          if (hwdata[`ITRF_ST_FABORT]) n.f_abort = 1'b0;
          if (hwdata[`ITRF_ST_FFP])    n.f_fp    = 1'b0;
        end

        // one command, one instruction
        // qp false on codes 1..7, 14, 15: no effect, no fault
        `ITRF_OFS_CMD: begin
          qp_true = pred_rd(s, hwdata[`ITRF_CMD_QP]);
          src_fr  = fr_rd(s, src);
          case (op)

            // with fault bit
            itrf_pkg::OP_WR_GR: if (qp_true) begin
              if (dst == 7'h0) begin
                n.f_const = 1'b1;
              end else begin
                n.gr[dst]     = s.d_mant;
                n.gr_nat[dst] = s.d_nat;
                if (dst >= `ITRF_STK_BASE) n.stk_valid[dst] = 1'b1;
              end
            end

            // speculation mark
            itrf_pkg::OP_SET_NAT: if (qp_true) begin
              if (dst == 7'h0) n.f_const = 1'b1;
              else n.gr_nat[dst] = 1'b1;
            end

            // sign/exp + mantissa
            itrf_pkg::OP_WR_FR: if (qp_true) begin
              if (dst <= 7'h1) n.f_const = 1'b1;
              else n.fr[dst] = {s.d_se, s.d_mant};
            end

            // zero drops silently
            itrf_pkg::OP_WR_PR: if (qp_true && dst[5:0] != 6'h0) begin
              n.pr[dst[5:0]] = s.d_mant[0];
            end

            // plain 64-bit writes
            itrf_pkg::OP_WR_BR: if (qp_true) n.br[dst[2:0]] = s.d_mant;
            itrf_pkg::OP_WR_AR: if (qp_true) n.ar[dst] = s.d_mant;
            itrf_pkg::OP_WR_IP: if (qp_true) n.ip = s.d_mant;

            // table entries
            itrf_pkg::OP_ADVANCED_LOAD_TABLE_SET: if (qp_true) begin
              n.advanced_load_table[dst[4:0]] = 1'b1;
            end
            itrf_pkg::OP_ADVANCED_LOAD_TABLE_CHECK: if (qp_true) n.advanced_load_table_hit = s.advanced_load_table[dst[4:0]];

            // only while engine runs
            itrf_pkg::OP_FLUSH: if (s.rse_active) begin
              n.clean = `ITRF_STK_N;
            end

            // table dropped, regs scanned
            // cvt turns fault values to snan
            itrf_pkg::OP_ENTER: if (!s.legacy) begin
              n.legacy = 1'b1;
              n.advanced_load_table   = '0;
              for (int i = `ITRF_LEG_LO; i <= `ITRF_LEG_HI; i++) begin
                if (s.gr_nat[i] || s.fr[i] == `ITRF_FP_DEFERRED_FAULT_FP_VALUE) pend = 1'b1;
                if (s.cvt_entry && s.fr[i] == `ITRF_FP_DEFERRED_FAULT_FP_VALUE) begin
                  n.fr[i] = `ITRF_FP_SNAN;
                end
              end
              n.abort_pend = pend;
            end

            // stack invalid, none clean
            itrf_pkg::OP_LEAVE: if (s.legacy) begin
              n.legacy     = 1'b0;
              n.stk_valid  = '0;
              n.clean      = 7'h0;
              n.abort_pend = 1'b0;
            end

            // int move between general regs
            // marked source aborts too
            itrf_pkg::OP_LEG_INT: if (s.legacy) begin
              // result lands in the same cycle the abort is reported
              if (dst == 7'h0) begin
                n.f_const = 1'b1;
              end else begin
                n.gr[dst]     = gr_rd(s, src);
                n.gr_nat[dst] = (src != 7'h0) & s.gr_nat[src];
              end
              if (s.abort_pend || ((src != 7'h0) && s.gr_nat[src])) begin
                n.f_abort = 1'b1;
              end
            end

            // policy 0 propagates, 1 faults
            // snan source always faults
            itrf_pkg::OP_LEG_FP: if (s.legacy) begin
              if (s.abort_pend) n.f_abort = 1'b1;
              if (src_fr == `ITRF_FP_DEFERRED_FAULT_FP_VALUE && !s.fp_pol) begin
                if (dst > 7'h1) n.fr[dst] = `ITRF_FP_DEFERRED_FAULT_FP_VALUE;
              end else if (src_fr == `ITRF_FP_DEFERRED_FAULT_FP_VALUE) begin
                n.fr[src] = `ITRF_FP_SNAN;
                n.f_fp    = 1'b1;
              end else if (src_fr == `ITRF_FP_SNAN) begin
                n.f_fp = 1'b1;
              end else if (dst <= 7'h1) begin
                n.f_const = 1'b1;
              end else begin
                n.fr[dst] = src_fr;
              end
            end

            // mantissa taken as data
            itrf_pkg::OP_LEG_VEC: if (s.legacy) begin
              // sign and exponent, deferred-fault encoding included, never looked at
              if (s.abort_pend) n.f_abort = 1'b1;
              if (dst <= 7'h1) n.f_const = 1'b1;
              else n.fr[dst] = {`ITRF_VEC_SE, src_fr[63:0]};
            end
            default: ;
          endcase
        end
        default: ; // unmapped or read-only: write ignored
      endcase
    end

    // an interruption also leaves legacy execution
    // a level held blocks entry
    // a pulse outside legacy: no-op
    if (legacy_interrupt && n.legacy) begin
      n.legacy     = 1'b0;
      n.stk_valid  = '0;
      n.clean      = 7'h0;
      n.abort_pend = 1'b0;
    end

    // engine enable is overridden while legacy code runs
    // next values: matches legacy_mode
    n.rse_active = n.rse_en & ~n.legacy;

    // address phase capture; reads get one wait state
    // writes never wait
    // reads: one wait, then hrdata
    if (take) begin
      n.haddr_q = haddr[7:0];
      n.wr_pend = hwrite;
      n.rd_pend = ~hwrite;
      if (!hwrite) n.hreadyout = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  // control defaults apart
  // so a new default is one edit

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s           <= '0;
      s.hreadyout <= 1'b1;
      {s.cvt_entry, s.fp_pol, s.rse_en} <= `ITRF_RST_CTRL;
    end else if (ce) begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from state
  // no logic from flops to pins
  assign hrdata      = s.hrdata;
  assign hreadyout   = s.hreadyout;
  assign hresp       = 1'b0; // always okay
  assign legacy_mode = s.legacy;
  assign rse_active  = s.rse_active;

endmodule : itrf_top

`default_nettype wire

/* verif/itrf_checker.sv */
/*
  Checker of the register file's bus handshake and mode outputs.
  Assumes it is bound to itrf_top; one clock, active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module itrf_checker (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // inputs watched
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        legacy_interrupt,
  // outputs watched
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        legacy_mode,
  input wire logic        rse_active
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // request taken at this edge
  wire logic take = hsel && htrans[1] && hready && ce;

  ////////////////////////////////////////////////////////////
  // a read holds the bus for exactly one wait cycle
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait;
    take && !hwrite |=> s_one_wait;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait is not one cycle");
  property p_wr_nowait;
    take && hwrite |=> hreadyout;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write inserted a wait");
  // a wait cycle only ever follows a taken read
  property p_ready_cause;
    $fell(hreadyout) |-> $past(take) && !$past(hwrite);
  endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("wait without a read");
  property p_resp_okay;
    hresp == 1'b0;
  endproperty
  a_resp_okay: assert property (p_resp_okay)
    else $error("response not okay");
  // frozen enable keeps legacy_mode, hrdata and hreadyout
  property p_ce_freeze;
    !ce |=> $stable(legacy_mode) && $stable(hrdata) && $stable(hreadyout);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("state moved while disabled");
  property p_rse_off;
    legacy_mode |-> !rse_active;
  endproperty
  a_rse_off: assert property (p_rse_off)
    else $error("stack engine active in legacy mode");
  property p_int_exit;
    ce && legacy_interrupt && legacy_mode |=> !legacy_mode;
  endproperty
  a_int_exit: assert property (p_int_exit)
    else $error("interruption did not leave legacy mode");
  property p_reset_vals;
    $rose(hresetn) |-> !legacy_mode && !rse_active && hreadyout && hrdata == 32'h0;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("outputs wrong after reset");
endmodule : itrf_checker

bind itrf_top itrf_checker u_chk (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .legacy_interrupt(legacy_interrupt),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .legacy_mode(legacy_mode), .rse_active(rse_active)
);

`default_nettype wire

/* verif/tb.sv */
/*
  Testbench of the register file: constants, widths, predication,
  legacy entry and exit, deferred-fault handling.
  Assumes the design's params header is on the include path.
*/
`include "itrf_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        ce      = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        leg_int = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        legacy_mode;
  logic        rse_active;
  logic [31:0] rv;
  logic [31:0] lo;
  logic [31:0] hi;
  logic [31:0] ex;
  int          bad_count = 0;
  int          tests_run = 0;

  // 100 MHz clock
  always #5 hclk = ~hclk;

  // hready tied back: the slave is alone on the bus
  itrf_top uut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .legacy_interrupt(leg_int), .legacy_mode(legacy_mode), .rse_active(rse_active)
  );

  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: word %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic chkb(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: flag %b expected %b", $time, g, e);
    end
  endtask : chkb

  // one single transfer; read data lands in rv; no cycle count assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 99);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 99);
    rv = hrdata;
    if (n >= 99) begin
      bad_count++;
      $display("mismatch at %0t: bus timeout", $time);
      stop_test();
    end
  endtask : bus

  // operand words, then the command that consumes them
  task automatic op(input logic [3:0] c, input logic [6:0] dst, input logic [6:0] src,
                    input logic [5:0] qp, input logic [31:0] l, input logic [31:0] x);
    bus(1'b1, `ITRF_OFS_DLO, l);
    bus(1'b1, `ITRF_OFS_DHI, l);
    bus(1'b1, `ITRF_OFS_DEX, x);
    bus(1'b1, `ITRF_OFS_CMD, {8'h0, qp, src, dst, c});
  endtask : op

  // one register through the read window
  task automatic get(input logic [2:0] cls, input logic [6:0] idx);
    bus(1'b1, `ITRF_OFS_RSEL, {21'h0, idx, 1'b0, cls});
    bus(1'b0, `ITRF_OFS_RLO, 32'h0);
    lo = rv;
    bus(1'b0, `ITRF_OFS_RHI, 32'h0);
    hi = rv;
    bus(1'b0, `ITRF_OFS_REX, 32'h0);
    ex = rv & 32'h8003ffff;
  endtask : get

  task automatic st();
    bus(1'b0, `ITRF_OFS_STAT, 32'h0);
  endtask : st

  ////////////////////////////////////////////////////////////
  // constant registers, with a frozen enable first
  task automatic t_const();
    ce <= 1'b0;
    repeat (3) @(posedge hclk);
    ce <= 1'b1;
    op(4'h1, 7'h0, 7'h0, 6'h0, 32'h5a, 32'h0);
    st();
    chkb(rv[2], 1'b1);
    get(3'h0, 7'h0);
    chk(lo, 32'h0);
    bus(1'b1, `ITRF_OFS_STAT, 32'h1c);
    op(4'h2, 7'h1, 7'h0, 6'h0, 32'h5a, 32'h1);
    st();
    chkb(rv[2], 1'b1);
    get(3'h1, 7'h1);
    chk(hi, 32'h80000000);
    chk(ex, 32'h0ffff);
    get(3'h1, 7'h0);
    chk(hi | ex, 32'h0);
    bus(1'b1, `ITRF_OFS_STAT, 32'h1c);
    op(4'h3, 7'h0, 7'h0, 6'h0, 32'h0, 32'h0);
    get(3'h2, 7'h0);
    chk(lo, 32'h1);
    st();
    chkb(rv[2], 1'b0);
    $display("constants test done");
  endtask : t_const

  // top indexes of each file, epilogue counter for application regs, then predication
  task automatic t_width();
    op(4'h1, 7'h7f, 7'h0, 6'h0, 32'hdead0001, 32'h0);
    op(4'h7, 7'h7f, 7'h0, 6'h0, 32'h0, 32'h0);
    get(3'h0, 7'h7f);
    chk(hi, 32'hdead0001);
    chkb(ex[31], 1'b1);
    chkb(rv[30], 1'b1);
    op(4'h2, 7'h7f, 7'h0, 6'h0, 32'hbeef, 32'h2abcd);
    get(3'h1, 7'h7f);
    chk(ex, 32'h2abcd);
    op(4'h3, 7'h3f, 7'h0, 6'h0, 32'h1, 32'h0);
    op(4'h4, 7'h7, 7'h0, 6'h0, 32'h77, 32'h0);
    op(4'h5, 7'h42, 7'h0, 6'h0, 32'h42, 32'h0);
    op(4'h6, 7'h0, 7'h0, 6'h0, 32'h1230, 32'h0);
    get(3'h3, 7'h7);
    chk(hi, 32'h77);
    get(3'h4, 7'h42);
    chk(lo, 32'h42);
    get(3'h5, 7'h0);
    chk(hi, 32'h1230);
    bus(1'b0, 8'h2c, 32'h0);
    chk(rv, 32'h0);
    op(4'h3, 7'h5, 7'h0, 6'h0, 32'h0, 32'h0);
    op(4'h1, 7'h3, 7'h0, 6'h0, 32'h5, 32'h0);
    op(4'h1, 7'h3, 7'h0, 6'h5, 32'h9, 32'h0);
    op(4'h1, 7'h0, 7'h0, 6'h5, 32'h9, 32'h0);
    get(3'h0, 7'h3);
    chk(lo, 32'h5);
    st();
    chkb(rv[2], 1'b0);
    op(4'h1, 7'h3, 7'h0, 6'h3f, 32'h9, 32'h0);
    get(3'h2, 7'h3f);
    chk(lo, 32'h1);
    get(3'h0, 7'h3);
    chk(lo, 32'h9);
    $display("width test done");
  endtask : t_width

  // stack engine, clean count and advanced-load table across legacy
  task automatic t_leg();
    bus(1'b1, `ITRF_OFS_CTRL, 32'h1);
    op(4'hd, 7'h0, 7'h0, 6'h0, 32'h0, 32'h0);
    op(4'he, 7'h3, 7'h0, 6'h0, 32'h0, 32'h0);
    op(4'hf, 7'h3, 7'h0, 6'h0, 32'h0, 32'h0);
    st();
    chk(rv & 32'h7f42, 32'h6042);
    chkb(rse_active, 1'b1);
    op(4'h8, 7'h0, 7'h0, 6'h0, 32'h0, 32'h0);
    st();
    chkb(legacy_mode, 1'b1);
    chkb(rv[1], 1'b0);
    op(4'h9, 7'h0, 7'h0, 6'h0, 32'h0, 32'h0);
    op(4'hf, 7'h3, 7'h0, 6'h0, 32'h0, 32'h0);
    st();
    chk(rv & 32'h7f41, 32'h0);
    get(3'h0, 7'h7f);
    chkb(rv[30], 1'b0);
    op(4'hd, 7'h0, 7'h0, 6'h0, 32'h0, 32'h0);
    op(4'h8, 7'h0, 7'h0, 6'h0, 32'h0, 32'h0);
    leg_int <= 1'b1;
    @(posedge hclk);
    leg_int <= 1'b0;
    st();
    chk(rv & 32'h7f01, 32'h0);
    $display("legacy transition test done");
  endtask : t_leg

  // deferred faults consumed by legacy instructions
  task automatic t_nat();
    op(4'h1, 7'hb, 7'h0, 6'h0, 32'h77, 32'h0);
    op(4'h1, 7'h9, 7'h0, 6'h0, 32'h1, 32'h80000000);
    bus(1'b1, `ITRF_OFS_CTRL, 32'h0);
    op(4'h8, 7'h0, 7'h0, 6'h0, 32'h0, 32'h0);
    op(4'ha, 7'ha, 7'hb, 6'h0, 32'h0, 32'h0);
    st();
    chk(rv & 32'h28, 32'h28);
    get(3'h0, 7'ha);
    chk(lo, 32'h77);
    op(4'h9, 7'h0, 7'h0, 6'h0, 32'h0, 32'h0);
    op(4'h1, 7'h9, 7'h0, 6'h0, 32'h1, 32'h0);
    op(4'h2, 7'hc, 7'h0, 6'h0, 32'h0, 32'h1fffe);
    bus(1'b1, `ITRF_OFS_STAT, 32'h1c);
    op(4'h8, 7'h0, 7'h0, 6'h0, 32'h0, 32'h0);
    op(4'hb, 7'hd, 7'hc, 6'h0, 32'h0, 32'h0);
    op(4'hc, 7'he, 7'hc, 6'h0, 32'h0, 32'h0);
    get(3'h1, 7'hd);
    chk(ex, 32'h1fffe);
    get(3'h1, 7'he);
    chk(ex, 32'h1003e);
    st();
    chkb(rv[4], 1'b0);
    bus(1'b1, `ITRF_OFS_CTRL, 32'h2);
    op(4'hb, 7'hf, 7'hc, 6'h0, 32'h0, 32'h0);
    st();
    chkb(rv[4], 1'b1);
    get(3'h1, 7'hf);
    chk(ex, 32'h0);
    get(3'h1, 7'hc);
    chk(ex, 32'h1ffff);
    chk(lo, 32'h1);
    op(4'h9, 7'h0, 7'h0, 6'h0, 32'h0, 32'h0);
    $display("deferred fault test done");
  endtask : t_nat

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_const();
    t_width();
    t_leg();
    t_nat();
    stop_test();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100us;
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : tb

`default_nettype wire
